// [src/bor_pkg.sv]
// package for the supply droop reset sequencer
// assumes a 200 mhz system clock and an analogue comparator outside
package bor_pkg;
    // clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // power-up hold time in milliseconds
    localparam int unsigned PWRUP_TIME_MS = 64;
    // cycles of the power-up hold
    // cycles per millisecond first, so the product stays inside 32 bits
    localparam int unsigned PWRUP_CYCLES =
        PWRUP_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    // least droop duration in nanoseconds
    localparam int unsigned DROOP_MIN_NS = 100;
    // cycles the droop must persist, rounded up
    localparam int unsigned DROOP_MIN_CYCLES =
        (DROOP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // enable field encodings
    localparam logic [1:0] EN_ALWAYS = 2'h3;
    localparam logic [1:0] EN_NO_SLEEP = 2'h2;
    // lowest trip level select code
    localparam logic LEVEL_LOWEST = 1'h0;
    // sequencer states
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_DROOP = 3'h2,
        ST_PWRUP = 3'h4
    } bor_state_type;
endpackage : bor_pkg

// [src/bor_seq.sv]
// supply droop reset sequencer: decodes config, filters droop,
// and holds the device reset through the power-up interval
// assumes comparator outputs for both trip levels, high when below
// Notes on behaviour
// - enable 11 always, 10 except sleep, 0x off
// - one config bit picks one of two levels
// - droop lasting at least the minimum resets the device
// - droop during power-up restarts the power-up timer
// - release reset 64 ms after supply recovers
// - erase forces enable at lowest level
module bor_seq #(
    parameter int unsigned PWRUP_CNT = bor_pkg::PWRUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [1:0] droop_reset_enable_field,
    input wire logic droop_trip_level_select,
    input wire logic below_low_level,
    input wire logic below_high_level,
    input wire logic sleep_active,
    input wire logic erase_active,
    output logic supply_droop_reset,
    output logic droop_flag
);
    // synchronised comparator outputs
    logic [1:0] below_sync;
    // current state and next
    bor_pkg::bor_state_type state_r;
    bor_pkg::bor_state_type state_nxt;
    // droop filter counter
    logic [7:0] droop_cnt_r;
    logic [7:0] droop_cnt_nxt;
    // power-up counter
    logic [23:0] pwrup_cnt_r;
    logic [23:0] pwrup_cnt_nxt;
    // outputs next values
    logic rst_nxt;
    // decoded controls
    wire enabled_cfg;
    wire enabled;
    wire level_sel;
    wire below;
    wire droop_long;
    wire pwrup_done;

    // detector inputs through a synchroniser
    bor_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({below_high_level, below_low_level}),
        .sync_out(below_sync)
    );

    // enable decode
    assign enabled_cfg =
        (droop_reset_enable_field == bor_pkg::EN_ALWAYS) ||
        ((droop_reset_enable_field == bor_pkg::EN_NO_SLEEP)
            && !sleep_active);
    // erase forces on
    assign enabled = enabled_cfg || erase_active;
    // level choice, erase forces lowest
    assign level_sel = erase_active ? bor_pkg::LEVEL_LOWEST
        : droop_trip_level_select;
    // selected comparator
    assign below = enabled &&
        (level_sel ? below_sync[1] : below_sync[0]);
    // droop persisted long enough
    assign droop_long =
        (droop_cnt_r >= 8'(bor_pkg::DROOP_MIN_CYCLES - 1));
    // power-up interval complete
    assign pwrup_done = (pwrup_cnt_r >= 24'(PWRUP_CNT - 1));

    // next-state decode
    always_comb begin
        state_nxt = state_r;
        droop_cnt_nxt = 8'h0;
        pwrup_cnt_nxt = 24'h0;
        unique case (state_r)
            bor_pkg::ST_RUN: begin
                // filter droop before tripping
                if (below) begin
                    droop_cnt_nxt = droop_cnt_r + 8'h1;
                    if (droop_long) begin
                        state_nxt = bor_pkg::ST_DROOP;
                    end
                end
            end
            bor_pkg::ST_DROOP: begin
                // wait for recovery
                if (!below) begin
                    state_nxt = bor_pkg::ST_PWRUP;
                end
            end
            bor_pkg::ST_PWRUP: begin
                // droop restarts timing
                if (below) begin
                    state_nxt = bor_pkg::ST_DROOP;
                end else if (pwrup_done) begin
                    state_nxt = bor_pkg::ST_RUN;
                end else begin
                    pwrup_cnt_nxt = pwrup_cnt_r + 24'h1;
                end
            end
            default: begin
                state_nxt = bor_pkg::ST_DROOP;
            end
        endcase
    end

    // reset held in every non-run state
    assign rst_nxt = (state_nxt != bor_pkg::ST_RUN);

    // state registers, start in reset hold
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= bor_pkg::ST_PWRUP;
            droop_cnt_r <= 8'h0;
            pwrup_cnt_r <= 24'h0;
            supply_droop_reset <= 1'h1;
            droop_flag <= 1'h0;
        end else begin
            state_r <= state_nxt;
            droop_cnt_r <= droop_cnt_nxt;
            pwrup_cnt_r <= pwrup_cnt_nxt;
            supply_droop_reset <= rst_nxt;
            droop_flag <= (state_nxt == bor_pkg::ST_DROOP);
        end
    end

    // assertions
    a_reset_held: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_r != bor_pkg::ST_RUN |-> supply_droop_reset)
        else $error("reset dropped outside run");
    a_trip_after_droop: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        state_r == bor_pkg::ST_RUN && below && droop_long
        |=> state_r == bor_pkg::ST_DROOP && supply_droop_reset)
        else $error("droop did not trip");
    a_restart_timer: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        state_r == bor_pkg::ST_PWRUP && below
        |=> state_r == bor_pkg::ST_DROOP ##1 pwrup_cnt_r == 24'h0)
        else $error("power-up timer not restarted");
    a_release_done: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        state_r == bor_pkg::ST_PWRUP && !below && pwrup_done
        |=> !supply_droop_reset)
        else $error("reset not released after interval");
    a_no_early_release: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        $fell(supply_droop_reset) |-> $past(pwrup_done))
        else $error("reset released early");
    a_disabled_quiet: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        !droop_reset_enable_field[1] && !erase_active |-> !below)
        else $error("detector live while disabled");
    a_sleep_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        droop_reset_enable_field == bor_pkg::EN_NO_SLEEP && sleep_active
        && !erase_active |-> !enabled)
        else $error("detector live in sleep");
    a_erase_low: assert property (@(posedge sys_clk) disable iff (!nrst)
        erase_active |-> enabled && below == below_sync[0])
        else $error("erase override wrong");
    a_level_pick: assert property (@(posedge sys_clk) disable iff (!nrst)
        enabled && !erase_active |->
        below == below_sync[droop_trip_level_select])
        else $error("wrong trip level used");
    c_trip: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_r == bor_pkg::ST_RUN ##1 state_r == bor_pkg::ST_DROOP);
    c_restart: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_r == bor_pkg::ST_PWRUP ##1 state_r == bor_pkg::ST_DROOP);
    c_release: cover property (@(posedge sys_clk) disable iff (!nrst)
        $fell(supply_droop_reset));

    // flag mirrors the droop state one for one
    a_flag_state: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        droop_flag == (state_r == bor_pkg::ST_DROOP))
        else $error("droop flag out of step with state");

    // power-up count is zero whenever a droop is being held
    a_count_cleared: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        state_r == bor_pkg::ST_DROOP |-> pwrup_cnt_r == 24'h0)
        else $error("power-up count kept during droop");

    // a short dip stays in run and clears the filter
    a_filter_clear: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        state_r == bor_pkg::ST_RUN && !below
        |=> state_r == bor_pkg::ST_RUN && droop_cnt_r == 8'h0)
        else $error("droop filter not cleared");

    // state register never leaves its one-hot codes
    a_state_legal: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        $onehot(state_r))
        else $error("illegal sequencer state");

    // trip taken while the erase override is in force
    c_erase_trip: cover property (@(posedge sys_clk) disable iff (!nrst)
        erase_active && state_r == bor_pkg::ST_RUN
        ##1 state_r == bor_pkg::ST_DROOP);
    // droop ignored while asleep with the sleep-gated code
    c_sleep_quiet: cover property (@(posedge sys_clk) disable iff (!nrst)
        sleep_active && !enabled && below_sync[0]);
endmodule // bor_seq

// [src/bor_sync.sv]
// two-flop synchroniser for the comparator outputs
// assumes inputs may change at any time
module bor_sync (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    // first stage, read only by the second
    logic [1:0] meta_r;
    // two stages per bit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // bor_sync

// [tb/bor_seq_tb.sv]
// self-checking bench for the supply droop reset sequencer
// assumes the sequencer carries its own assertions; no partner model
module bor_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PW = 50; // shortened power-up hold
    logic sys_clk = 1'h0; // 200 mhz clock
    logic nrst = 1'h0; // async reset, low active
    logic [1:0] droop_reset_enable_field = 2'h3; // enable code
    logic droop_trip_level_select = 1'h0; // trip level pick
    logic below_low_level = 1'h0; // low comparator
    logic below_high_level = 1'h0; // high comparator
    logic sleep_active = 1'h0;
    logic erase_active = 1'h0;
    logic supply_droop_reset;
    logic droop_flag;
    int fail_count = 0; // mismatches
    int samples_checked = 0; // comparisons made

    // half period of 2.5 ns
    always #2.5 sys_clk = ~sys_clk;

    bor_seq #(.PWRUP_CNT(PW)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .droop_reset_enable_field(droop_reset_enable_field),
        .droop_trip_level_select(droop_trip_level_select),
        .below_low_level(below_low_level),
        .below_high_level(below_high_level),
        .sleep_active(sleep_active), .erase_active(erase_active),
        .supply_droop_reset(supply_droop_reset), .droop_flag(droop_flag));

    // wait edges, then drive just after the last one
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one comparison
    task automatic chk(string nm, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %b got %b", nm, exp, got);
        end
    endtask

    // hold a droop for n edges, judge, recover and time the release
    task automatic trip(logic lo, logic hi, int n, logic exp);
        int c;
        {below_low_level, below_high_level} = {lo, hi};
        step(n);
        chk("reset", exp, supply_droop_reset);
        chk("flag", exp, droop_flag);
        {below_low_level, below_high_level} = 2'h0;
        c = 0;
        while (supply_droop_reset === 1'h1 && c < 300) begin
            step(1);
            c++;
        end
        if (exp) chk("release", 1'h1, 1'(c >= PW && c <= PW + 8));
    endtask

    // out of reset: hold then release
    task automatic t_reset();
        int c;
        chk("reset in reset", 1'h1, supply_droop_reset);
        chk("flag in reset", 1'h0, droop_flag);
        nrst = 1'h1;
        c = 0;
        while (supply_droop_reset === 1'h1 && c < 300) begin
            step(1);
            c++;
        end
        chk("first release", 1'h1, 1'(c >= PW - 2 && c <= PW + 4));
    endtask

    // level pick and droop length
    task automatic t_levels();
        droop_trip_level_select = 1'h0;
        trip(1'h1, 1'h0, 25, 1'h1);
        trip(1'h0, 1'h1, 30, 1'h0);
        trip(1'h1, 1'h0, 10, 1'h0);
        droop_trip_level_select = 1'h1;
        trip(1'h1, 1'h0, 30, 1'h0);
        trip(1'h1, 1'h1, 25, 1'h1);
        droop_trip_level_select = 1'h0;
    endtask

    // every enable code, code 10 with and without sleep
    task automatic t_modes();
        logic [2:0] mode [5] = '{3'h7, 3'h4, 3'h5, 3'h2, 3'h0};
        logic [4:0] expv = 5'h18;
        for (int i = 0; i < 5; i++) begin
            {droop_reset_enable_field, sleep_active} = mode[i];
            trip(1'h1, 1'h0, 30, expv[4 - i]);
        end
        {droop_reset_enable_field, sleep_active} = 3'h6;
    endtask

    // erase overrides disable and the high level pick
    task automatic t_erase();
        droop_reset_enable_field = 2'h0;
        droop_trip_level_select = 1'h1;
        erase_active = 1'h1;
        trip(1'h0, 1'h1, 30, 1'h0);
        trip(1'h1, 1'h0, 25, 1'h1);
        erase_active = 1'h0;
        droop_reset_enable_field = 2'h3;
        droop_trip_level_select = 1'h0;
    endtask

    // droop in mid power-up restarts the hold from the start
    task automatic t_restart();
        below_low_level = 1'h1;
        step(25);
        below_low_level = 1'h0;
        step(PW / 2);
        trip(1'h1, 1'h0, 25, 1'h1);
    endtask

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog well past the expected run
    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    // main sequence
    initial begin
        step(4);
        t_reset();
        t_levels();
        t_modes();
        t_erase();
        t_restart();
        test_done();
    end
endmodule // bor_seq_tb
